/* verification/change_detect_reference_debounce_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module change_detect_reference_debounce_tb_top;
    // ----
    // Stimulus and observed signals
    // ----
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        clkEnable = 1'b1;
    logic        deviceActive = 1'b0;
    logic        sampleStrobe = 1'b0;
    logic [11:0] sampleX = 12'h000, sampleY = 12'h000, sampleZ = 12'h000, magnitude = 12'h000;
    logic [2:0]  outsideAxis = 3'h0, withinAxis = 3'h0, outsideAxisEnable = 3'h4, withinAxisEnable = 3'h7;
    logic [7:0]  outTh = 8'h00, winTh = 8'h00;
    wire         ctrlWrite, outsideEventFlag, withinEventFlag;
    wire  [7:0]  ctrlWriteData, ctrlReadData;
    wire  [11:0] referenceX, referenceY, referenceZ, compareX;
    int          error_cnt = 0, tests_run = 0, cycles = 0;

    always #4 sys_clk = ~sys_clk;
    host_model i_host_model (.sys_clk(sys_clk), .ctrlWrite(ctrlWrite), .ctrlWriteData(ctrlWriteData));
    change_detector_control i_change_detector_control (
        .sys_clk(sys_clk), .rst_b(rst_b), .clkEnable(clkEnable), .ctrlWrite(ctrlWrite),
        .ctrlWriteData(ctrlWriteData), .ctrlReadData(ctrlReadData), .deviceActive(deviceActive),
        .sampleStrobe(sampleStrobe), .sampleX(sampleX), .sampleY(sampleY), .sampleZ(sampleZ),
        .magnitude(magnitude), .outsideAxis(outsideAxis), .withinAxis(withinAxis),
        .outsideAxisEnable(outsideAxisEnable), .withinAxisEnable(withinAxisEnable),
        .outsideDebounceThreshold(outTh), .withinDebounceThreshold(winTh), .referenceX(referenceX),
        .referenceY(referenceY), .referenceZ(referenceZ), .compareX(compareX),
        .outsideEventFlag(outsideEventFlag), .withinEventFlag(withinEventFlag));

    // Hang guard: the whole sequence needs about 140 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    // ----
    // Checking and stimulus tasks
    // ----
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One sample period; outputs are read after the sampling edge has landed
    task automatic stb(input logic [11:0] v, input logic [2:0] o, input logic [2:0] w);
        @(posedge sys_clk);
        sampleStrobe <= 1'b1;
        sampleX <= v;
        sampleY <= ~v;
        sampleZ <= v ^ 12'h0f0;
        magnitude <= v + 12'h001;
        outsideAxis <= o;
        withinAxis <= w;
        @(posedge sys_clk);
        sampleStrobe <= 1'b0;
        #1;
    endtask
    task automatic ref3(input logic [11:0] v);
        chk("referenceX", v, referenceX);
        chk("referenceY", ~v, referenceY);
        chk("referenceZ", v ^ 12'h0f0, referenceZ);
    endtask
    // All three references at zero
    task automatic zero3;
        chk("referenceX", 12'h000, referenceX);
        chk("referenceY", 12'h000, referenceY);
        chk("referenceZ", 12'h000, referenceZ);
    endtask
    // Disable, re-enable with a setup, then the capture-only first strobe
    task automatic start(input logic [7:0] cfg);
        i_host_model.wr(8'h00);
        i_host_model.wr(cfg);
        stb(12'h055, 3'h0, 3'h0);
    endtask
    // Debounce run: pattern bit i drives period i; outside gets X only, within all three axes or only X when part is set
    task automatic run(input logic [7:0] cfg, input logic [7:0] th, input logic part, input logic [11:0] pat,
                       input logic [11:0] expO, input logic [11:0] expW, input int n);
        @(posedge sys_clk);
        outTh <= th;
        winTh <= th;
        start(cfg);
        for (int i = 0; i < n; i++) begin
            stb(12'h100 + 12'(i), pat[i] ? 3'h4 : 3'h0, pat[i] ? (part ? 3'h4 : 3'h7) : 3'h0);
            chk("outside flag", {11'h0, expO[i]}, {11'h0, outsideEventFlag});
            chk("within flag", {11'h0, expW[i]}, {11'h0, withinEventFlag});
        end
    endtask
    task automatic report_and_stop;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1;
        chk("control reset", 12'h000, {4'h0, ctrlReadData});
        zero3();
        i_host_model.wr(8'h5f);
        chk("control readback", 12'h05f, {4'h0, ctrlReadData});
        stb(12'h011, 3'h0, 3'h0);
        chk("refresh clear", 12'h05e, {4'h0, ctrlReadData});
        @(posedge sys_clk);
        deviceActive <= 1'b1;
        start(8'he0);
        zero3();
        i_host_model.wr(8'he1);
        stb(12'h777, 3'h0, 3'h0);
        zero3();
        start(8'ha0);
        ref3(12'h055);
        stb(12'h0aa, 3'h0, 3'h0);
        ref3(12'h055);
        i_host_model.wr(8'ha1);
        stb(12'h0bb, 3'h0, 3'h0);
        ref3(12'h0bb);
        chk("refresh done", 12'h0a0, {4'h0, ctrlReadData});
        start(8'hc0);
        stb(12'h234, 3'h0, 3'h0);
        ref3(12'h234);
        start(8'h82);
        chk("compareX", 12'h056, compareX);
        chk("magnitude reference", 12'h056, referenceX);
        run(8'h80, 8'h02, 1'b0, 12'hc13, 12'h87e, 12'h87e, 12);
        stb(12'h321, 3'h0, 3'h0);
        chk("event reload", 12'h321, referenceX);
        run(8'h98, 8'h02, 1'b0, 12'h01b, 12'h012, 12'h012, 5);
        run(8'h9c, 8'h00, 1'b1, 12'h005, 12'h005, 12'h005, 4);
        run(8'h98, 8'h00, 1'b1, 12'h005, 12'h005, 12'h000, 4);
        run(8'h9a, 8'h00, 1'b1, 12'h005, 12'h005, 12'h005, 4);
        report_and_stop();
    end
endmodule // change_detect_reference_debounce_tb_top
`default_nettype wire

/* verification/change_detector_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Control port and debounce behaviour checks
// ----
module change_detector_properties (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_b,
    // Design inputs
    input wire logic        clkEnable,
    input wire logic        ctrlWrite,
    input wire logic [7:0]  ctrlWriteData,
    input wire logic        deviceActive,
    input wire logic        sampleStrobe,
    input wire logic [11:0] sampleX,
    input wire logic [11:0] magnitude,
    input wire logic [2:0]  outsideAxis,
    input wire logic [2:0]  withinAxis,
    input wire logic [2:0]  outsideAxisEnable,
    input wire logic [2:0]  withinAxisEnable,
    input wire logic [7:0]  outsideDebounceThreshold,
    // Design outputs
    input wire logic [7:0]  ctrlReadData,
    input wire logic [11:0] referenceX,
    input wire logic [11:0] referenceY,
    input wire logic [11:0] referenceZ,
    input wire logic [11:0] compareX,
    input wire logic        outsideEventFlag,
    input wire logic        withinEventFlag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Evaluated strobe; a write in the same cycle may alter the setup, so skip it
    wire       en   = ctrlReadData[7];
    wire       tick = sampleStrobe && clkEnable && !ctrlWrite;
    // Magnitude input leaves only the X channel
    wire [2:0] oMsk = ctrlReadData[1] ? (outsideAxisEnable & 3'h4) : outsideAxisEnable;
    wire [2:0] wMsk = ctrlReadData[1] ? (withinAxisEnable & 3'h4) : withinAxisEnable;
    wire       oHit = |(outsideAxis & oMsk);
    wire       wHit = ctrlReadData[2] ? |(withinAxis & wMsk) : (wMsk != 3'h0 && (withinAxis & wMsk) == wMsk);
    // Consecutive false outside periods so far; restarts like the design's counters
    logic [7:0] oFalse;
    logic       actQ;
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            oFalse <= 8'h00;
            actQ   <= 1'b0;
        end else if (clkEnable) begin
            actQ <= deviceActive;
            if (!en || deviceActive != actQ)
                oFalse <= 8'h00;
            else if (sampleStrobe)
                oFalse <= oHit ? 8'h00 : oFalse + {7'h00, oFalse != 8'hff};
        end
    end

    property p_absolute_zero;
        (ctrlReadData[6:5] == 2'h3)[*2] |-> {referenceX, referenceY, referenceZ} == 36'h0;
    endproperty
    a_absolute_zero: assert property (p_absolute_zero)
        else $error("reference not zero under absolute policy");
    property p_slope;
        en && ctrlReadData[6:5] == 2'h2 && !ctrlReadData[1] && tick |=> referenceX == $past(sampleX);
    endproperty
    a_slope: assert property (p_slope)
        else $error("slope reference not previous sample");
    property p_select;
        en && tick |=> compareX == ($past(ctrlReadData[1]) ? $past(magnitude) : $past(sampleX));
    endproperty
    a_select: assert property (p_select)
        else $error("compare channel source wrong");
    property p_self_clear;
        ctrlReadData[0] && sampleStrobe && clkEnable && !(ctrlWrite && ctrlWriteData[0]) |=> !ctrlReadData[0];
    endproperty
    a_self_clear: assert property (p_self_clear)
        else $error("refresh bit did not clear");
    property p_write;
        ctrlWrite && clkEnable |=> ctrlReadData[7:1] == $past(ctrlWriteData[7:1])
            && (ctrlReadData[0] || !$past(ctrlWriteData[0]));
    endproperty
    a_write: assert property (p_write)
        else $error("control write not taken");
    property p_out_clear;
        en && ctrlReadData[4] && tick && !oHit |=> !outsideEventFlag;
    endproperty
    a_out_clear: assert property (p_out_clear)
        else $error("outside flag kept in clear mode");
    property p_win_clear;
        en && ctrlReadData[3] && tick && !wHit |=> !withinEventFlag;
    endproperty
    a_win_clear: assert property (p_win_clear)
        else $error("within flag kept in clear mode");
    property p_out_hold;
        en && !ctrlReadData[4] && outsideEventFlag && outsideDebounceThreshold != 8'h00
            && oFalse < outsideDebounceThreshold && tick && !oHit && $stable(deviceActive) |=> outsideEventFlag;
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("outside flag dropped too early");
endmodule // change_detector_properties

bind change_detector_control change_detector_properties i_change_detector_properties (
    .sys_clk(sys_clk), .rst_b(rst_b), .clkEnable(clkEnable), .ctrlWrite(ctrlWrite),
    .ctrlWriteData(ctrlWriteData), .deviceActive(deviceActive), .sampleStrobe(sampleStrobe),
    .sampleX(sampleX), .magnitude(magnitude), .outsideAxis(outsideAxis), .withinAxis(withinAxis),
    .outsideAxisEnable(outsideAxisEnable), .withinAxisEnable(withinAxisEnable),
    .outsideDebounceThreshold(outsideDebounceThreshold), .ctrlReadData(ctrlReadData),
    .referenceX(referenceX), .referenceY(referenceY), .referenceZ(referenceZ), .compareX(compareX),
    .outsideEventFlag(outsideEventFlag), .withinEventFlag(withinEventFlag)
);
`default_nettype wire

/* verification/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Host writing the control register
// ----
module host_model (
    // Clock
    input  wire logic       sys_clk,
    // Control register port
    output var  logic       ctrlWrite,
    output var  logic [7:0] ctrlWriteData
);
    logic magnitudeCalcEnable; // Sensor-side magnitude calc switch
    initial begin
        ctrlWrite = 1'b0;
        ctrlWriteData = 8'h00;
        magnitudeCalcEnable = 1'b0;
    end
    // One-cycle strobe; magnitude calc switched on before magnitude input is chosen
    task automatic wr(input logic [7:0] d);
        if (d[1]) magnitudeCalcEnable = 1'b1;
        @(posedge sys_clk);
        ctrlWrite <= 1'b1;
        ctrlWriteData <= d;
        @(posedge sys_clk);
        ctrlWrite <= 1'b0;
        #1;
    endtask
endmodule // host_model
`default_nettype wire

/* verilog/change_detector_control.v */
// What this block does
// - Slope policy: reference follows previous sample
// - Absolute policy: reference is zero
// - Outside decrement mode decrements on false
// - Outside flagged: release after count+1 falses
// - Outside clear mode zeroes counter on false
// - Within decrement mode decrements on false
// - Within flagged: release after count+1 falses
// - Within clear mode zeroes counter on false
// - Within combine: AND or OR of axes
// - Input select: axes or magnitude on X
// - Refresh request reloads reference next sample
// - Refresh under absolute policy keeps zero
// - Refresh bit self-clears at the next sample strobe, reload or not
// - Refresh writes accepted active or standby
// - Control bits 4..0 placement fixed
// - Policy 00: first sample, reload on outside event
// - Policy 01: first sample, hold until refresh
// - Policy in bits 6:5, enable bit 7
`timescale 1ns/1ps
`default_nettype none
`include "change_detector_map.vh"

module change_detector_control #(
    parameter SW = `SAMPLE_WIDTH,   // Sample width
    parameter CW = `COUNT_WIDTH     // Debounce count width
) (
    // Clock, reset, clock enable
    input  wire          sys_clk,
    input  wire          rst_b,
    input  wire          clkEnable,
    // Control register port
    input  wire          ctrlWrite,       // One-cycle write strobe
    input  wire [7:0]    ctrlWriteData,
    output wire [7:0]    ctrlReadData,
    // Operating state and sample timing
    input  wire          deviceActive,    // 1 active, 0 standby
    input  wire          sampleStrobe,    // One pulse per output sample period
    // Current decimated, trimmed data
    input  wire [SW-1:0] sampleX,
    input  wire [SW-1:0] sampleY,
    input  wire [SW-1:0] sampleZ,
    input  wire [SW-1:0] magnitude,
    // Per-axis window results from the comparator, X in bit 2
    input  wire [2:0]    outsideAxis,
    input  wire [2:0]    withinAxis,
    input  wire [2:0]    outsideAxisEnable,
    input  wire [2:0]    withinAxisEnable,
    // Debounce thresholds
    input  wire [CW-1:0] outsideDebounceThreshold,
    input  wire [CW-1:0] withinDebounceThreshold,
    // Reference triplet to the comparator
    output reg  [SW-1:0] referenceX,
    output reg  [SW-1:0] referenceY,
    output reg  [SW-1:0] referenceZ,
    // Selected X-channel data
    output reg  [SW-1:0] compareX,
    // Event flags
    output wire          outsideEventFlag,
    output wire          withinEventFlag
);

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    reg          detectorEnable;          // Bit 7
    reg  [1:0]   referencePolicy;         // Bits 6:5
    reg          outsideDebounceBehaviour;// Bit 4, 1 = clear
    reg          withinDebounceBehaviour; // Bit 3, 1 = clear
    reg          withinAxisCombine;       // Bit 2, 1 = OR
    reg          inputSelect;             // Bit 1, 1 = magnitude
    reg          referenceRefreshRequest; // Bit 0, self clearing
    reg          firstSamplePending;      // Capture after enable
    reg          lastActive;              // For state-change detect

    // Read-back: all bits straight from flip-flops
    assign ctrlReadData = {detectorEnable, referencePolicy,
                           outsideDebounceBehaviour, withinDebounceBehaviour,
                           withinAxisCombine, inputSelect,
                           referenceRefreshRequest};

    // ------------------------------------------------------------
    // Evaluation and combining
    // ------------------------------------------------------------
    wire         enableRising  = ctrlWrite & ctrlWriteData[`CTRL_ENABLE_BIT] & ~detectorEnable;
    wire         evaluate      = sampleStrobe & detectorEnable & ~firstSamplePending;
    // State change between active and standby restarts the counters
    wire         restartCount  = ~detectorEnable | (deviceActive ^ lastActive);

    // Magnitude input uses the X channel only
    wire [2:0]   channelMask   = inputSelect ? `AXIS_X_ONLY : 3'h7;
    wire [2:0]   outsideUsed   = outsideAxisEnable & channelMask;
    wire [2:0]   withinUsed    = withinAxisEnable & channelMask;

    // Outside result: any enabled axis outside the window
    wire         outsideResult = |(outsideAxis & outsideUsed);
    // Within result: AND or OR over the enabled axes
    wire         withinAnd     = (withinUsed != 3'h0) & ((withinAxis & withinUsed) == withinUsed);
    wire         withinOr      = |(withinAxis & withinUsed);
    wire         withinResult  = withinAxisCombine ? withinOr : withinAnd;

    // Channel data after input selection
    wire [SW-1:0] currentX     = inputSelect ? magnitude : sampleX;

    // ------------------------------------------------------------
    // Control register write and self-clearing refresh
    // ------------------------------------------------------------
    // Refresh completes at the next sample strobe; a new write in that
    // same cycle wins so no request is lost
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            detectorEnable           <= 1'b0;
            referencePolicy          <= `POLICY_FOLLOW_EVENT;
            outsideDebounceBehaviour <= 1'b0;
            withinDebounceBehaviour  <= 1'b0;
            withinAxisCombine        <= 1'b0;
            inputSelect              <= 1'b0;
            referenceRefreshRequest  <= 1'b0;
            lastActive               <= 1'b0;
        end else if (clkEnable) begin
            lastActive <= deviceActive;
            if (ctrlWrite) begin
                // Accepted regardless of active or standby state
                detectorEnable           <= ctrlWriteData[`CTRL_ENABLE_BIT];
                referencePolicy          <= ctrlWriteData[`CTRL_POLICY_HI:`CTRL_POLICY_LO];
                outsideDebounceBehaviour <= ctrlWriteData[`CTRL_OUT_MODE_BIT];
                withinDebounceBehaviour  <= ctrlWriteData[`CTRL_WIN_MODE_BIT];
                withinAxisCombine        <= ctrlWriteData[`CTRL_COMBINE_BIT];
                inputSelect              <= ctrlWriteData[`CTRL_INSEL_BIT];
            end
            if (ctrlWrite && ctrlWriteData[`CTRL_REFRESH_BIT]) begin
                // Writing one raises the request in any state
                referenceRefreshRequest <= 1'b1;
            end else if (sampleStrobe) begin
                // Bit drops on this strobe; the reload happens only while enabled
                referenceRefreshRequest <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Reference triplet
    // ------------------------------------------------------------
    // Reload decisions for the current sample strobe
    reg loadReference;
    always @* begin
        loadReference = 1'b0;
        if (sampleStrobe && detectorEnable) begin
            if (firstSamplePending || referenceRefreshRequest) begin
                loadReference = 1'b1;
            end else begin
                case (referencePolicy)
                    `POLICY_FOLLOW_EVENT: loadReference = outsideEventFlag;
                    `POLICY_HOLD:         loadReference = 1'b0;
                    `POLICY_SLOPE:        loadReference = 1'b1;
                    default:              loadReference = 1'b0;
                endcase
            end
        end
    end

    // Absolute policy pins the reference at zero; a refresh there is void
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            referenceX         <= `REF_ZERO;
            referenceY         <= `REF_ZERO;
            referenceZ         <= `REF_ZERO;
            firstSamplePending <= 1'b0;
        end else if (clkEnable) begin
            if (enableRising) begin
                // Enabling initialises the reference per the policy
                firstSamplePending <= 1'b1;
            end else if (sampleStrobe && detectorEnable) begin
                firstSamplePending <= 1'b0;
            end
            if (referencePolicy == `POLICY_ABSOLUTE) begin
                referenceX <= `REF_ZERO;
                referenceY <= `REF_ZERO;
                referenceZ <= `REF_ZERO;
            end else if (loadReference) begin
                // Slope: stored after evaluation, used next period
                referenceX <= currentX;
                referenceY <= sampleY;
                referenceZ <= sampleZ;
            end
        end
    end

    // ------------------------------------------------------------
    // Selected channel data to the comparator
    // ------------------------------------------------------------
    // Registered so the comparator sees stable data between strobes
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            compareX <= `REF_ZERO;
        end else if (clkEnable && sampleStrobe) begin
            compareX <= currentX;
        end
    end

    // ------------------------------------------------------------
    // Debounce counters
    // ------------------------------------------------------------
    // Magnitude input without the host's magnitude calculation gives
    // meaningless results; this block cannot detect that case
    debounce_counter #(
        .WIDTH (CW)
    ) outsideDebounce (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .clkEnable (clkEnable),
        .step      (evaluate),
        .restart   (restartCount),
        .clearMode (outsideDebounceBehaviour),
        .condition (outsideResult),
        .threshold (outsideDebounceThreshold),
        .count     (),
        .eventFlag (outsideEventFlag)
    );

    debounce_counter #(
        .WIDTH (CW)
    ) withinDebounce (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .clkEnable (clkEnable),
        .step      (evaluate),
        .restart   (restartCount),
        .clearMode (withinDebounceBehaviour),
        .condition (withinResult),
        .threshold (withinDebounceThreshold),
        .count     (),
        .eventFlag (withinEventFlag)
    );

endmodule // change_detector_control
`default_nettype wire

/* verilog/change_detector_map.vh */
`ifndef CHANGE_DETECTOR_MAP_VH
`define CHANGE_DETECTOR_MAP_VH

// ----------------------------------------------------------------
// Detector control register layout
// ----------------------------------------------------------------
`define CTRL_ADDR            8'h30
`define CTRL_RESET           8'h00
`define CTRL_ENABLE_BIT      7
`define CTRL_POLICY_HI       6
`define CTRL_POLICY_LO       5
`define CTRL_OUT_MODE_BIT    4
`define CTRL_WIN_MODE_BIT    3
`define CTRL_COMBINE_BIT     2
`define CTRL_INSEL_BIT       1
`define CTRL_REFRESH_BIT     0

// ----------------------------------------------------------------
// Reference policy codes
// ----------------------------------------------------------------
`define POLICY_FOLLOW_EVENT  2'h0
`define POLICY_HOLD          2'h1
`define POLICY_SLOPE         2'h2
`define POLICY_ABSOLUTE      2'h3

// ----------------------------------------------------------------
// Widths and fixed values
// ----------------------------------------------------------------
`define SAMPLE_WIDTH         12
`define COUNT_WIDTH          8
`define REF_ZERO             12'h000
`define COUNT_ZERO           8'h00
`define COUNT_ONE            8'h01
`define AXIS_X_ONLY          3'h4

`endif

/* verilog/debounce_counter.v */
`timescale 1ns/1ps
`default_nettype none
`include "change_detector_map.vh"

// ----------------------------------------------------------------
// One debounce counter with its event flag
// ----------------------------------------------------------------
module debounce_counter #(
    parameter WIDTH = `COUNT_WIDTH
) (
    // Clock, reset, enable
    input  wire             sys_clk,
    input  wire             rst_b,
    input  wire             clkEnable,
    // Control
    input  wire             step,        // One sample period evaluated
    input  wire             restart,     // Clears count and flag
    input  wire             clearMode,   // 1: clear on false, 0: decrement
    input  wire             condition,   // Combined result this period
    input  wire [WIDTH-1:0] threshold,   // Programmed debounce count
    // Results
    output reg  [WIDTH-1:0] count,
    output reg              eventFlag
);

    localparam [WIDTH-1:0] ZERO = {WIDTH{1'b0}};
    localparam [WIDTH-1:0] ONE  = {{(WIDTH-1){1'b0}}, 1'b1};

    // Count up while true, release per mode while false
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            count     <= ZERO;
            eventFlag <= 1'b0;
        end else if (clkEnable) begin
            if (restart) begin
                count     <= ZERO;
                eventFlag <= 1'b0;
            end else if (step) begin
                if (condition) begin
                    if (eventFlag) begin
                        // Re-arm the release window to the full count
                        count <= threshold;
                    end else if (count >= threshold) begin
                        eventFlag <= 1'b1;
                    end else begin
                        count <= count + ONE;
                        if (count + ONE == threshold)
                            eventFlag <= 1'b1;
                    end
                end else if (clearMode) begin
                    // Any false period drops the count at once
                    count     <= ZERO;
                    eventFlag <= 1'b0;
                end else if (count == ZERO) begin
                    // Count+1 false periods needed before release
                    eventFlag <= 1'b0;
                end else begin
                    // Saturating decrement, never wraps below zero
                    count <= count - ONE;
                end
            end
        end
    end

endmodule // debounce_counter
`default_nettype wire
